// file: inc/tec_pkg.sv
// Package for the 16-bit timer/event counter with two capture/compare registers.
// Assumes an APB slave with 32-bit data and word-aligned register offsets.
package tec_pkg;
  localparam logic [7:0]  OFS_MODE     = 8'h00;
  localparam logic [7:0]  OFS_PRESC    = 8'h04;
  localparam logic [7:0]  OFS_CAPCTRL  = 8'h08;
  localparam logic [7:0]  OFS_OUTCTRL  = 8'h0c;
  localparam logic [7:0]  OFS_COUNTER  = 8'h10;
  localparam logic [7:0]  OFS_CC_FIRST = 8'h14;
  localparam logic [7:0]  OFS_CC_SECND = 8'h18;
  localparam logic [7:0]  OFS_STATUS   = 8'h1c;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  localparam logic [7:0]  REG8_RST     = 8'h00;
  localparam logic [3:0]  DIV_MASK_2   = 4'h1;
  localparam logic [3:0]  DIV_MASK_4   = 4'h3;
  localparam logic [3:0]  DIV_MASK_8   = 4'h7;
  localparam logic [3:0]  DIV_MASK_16  = 4'hf;

  typedef enum logic [1:0] {
    TEC_STOP       = 2'b00,
    TEC_CLR_EDGE   = 2'b01,
    TEC_FREE       = 2'b10,
    TEC_CLR_MATCH  = 2'b11
  } tec_mode_t;

  typedef enum logic [1:0] {
    TEC_CLK_DIV2   = 2'b00,
    TEC_CLK_DIV4   = 2'b01,
    TEC_CLK_DIV16  = 2'b10,
    TEC_CLK_EXT    = 2'b11
  } tec_clk_t;

  // Edge selection codes; 2'b10 selects no edge.
  localparam logic [1:0]  EDGE_FALL    = 2'b00;
  localparam logic [1:0]  EDGE_RISE    = 2'b01;
  localparam logic [1:0]  EDGE_BOTH    = 2'b11;

  // Prescaler mode register: [1:0] clock, [5:4] first edge, [7:6] second edge.
  typedef struct packed {
    logic [1:0] edge_sel_second;
    logic [1:0] edge_sel_first;
    logic [1:0] unused;
    tec_clk_t   clk_sel;
  } tec_presc_t;

  // Capture control: bit0 first reg captures, bit1 first reg uses inverse
  // first-input edge, bit2 second reg captures.
  typedef struct packed {
    logic [4:0] unused;
    logic       capture_ctrl_bit2;
    logic       capture_ctrl_bit1;
    logic       capture_ctrl_bit0;
  } tec_capctrl_t;
endpackage

// file: core/tec_timer.sv
// Functional notes
// - Event mode: shared pin never drives output.
// - Event mode overflow in clear-on-match mode only with first register FFFFH.
// - Both output bits set: pin toggles per match.
// - Start to first match may slip one count.
// - Capture during read still happens, pulse raised.
// - Capture registers keep their values after stopping.
// - Overflow flag sets on wrap FFFFH to 0000H.
// - Overflow clear ignored until counter reaches 0001H.
// - Reading counter never latches second register.
// - Stopped timer ignores both input pins.
// - Count-clock pin cannot trigger its capture.
// - Both first-pin edges selected: first register never captures on the inverse first-pin edge.
// - Capture on count tick (fx/8 tick in event mode), pulse two cycles later.
// - Compare-mode register ignores capture triggers.
// - High pin after reset gives immediate rising edge.
// - Filter samples twice; fx/8 or count clock.
// - Event mode counts edges, clears on match only in clear-on-match mode.
//
// Timer/event counter core: APB register slave, prescaler, input filters,
// counter, capture/compare and square-wave output.
// Assumes one 25 MHz clock; input pins are asynchronous to it.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tec_timer
  import tec_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        ext_input_first_in,
  input  wire logic        ext_input_second_in,
  output logic             timer_output_pin_out,
  output logic             timer_output_oe_out,
  output logic             first_match_irq_out,
  output logic             second_capture_irq_out
);
  tec_mode_t    timer_mode_reg;
  tec_presc_t   prescaler_mode_reg;
  tec_capctrl_t capture_control_reg;
  logic [7:0]   output_control_reg;
  logic [15:0]  main_counter;
  logic [15:0]  capcmp_reg_first;
  logic [15:0]  capcmp_reg_second;
  logic         overflow_flag;
  logic         ovf_hold;
  logic         ran_once;
  logic [3:0]   presc;
  logic [1:0]   sync_a;
  logic [1:0]   sync_b;
  logic         samp_a;
  logic         samp_b;
  logic         acc_a;
  logic         acc_b;
  logic         pend_first;
  logic         pend_second;

  function automatic logic edge_hit(input logic old_lvl, input logic new_lvl,
                                    input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = !old_lvl && new_lvl;
    fall = old_lvl && !new_lvl;
    case (sel)
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = rise || fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  logic running;
  logic event_mode;
  logic div_tick;
  logic filt_tick_a;
  logic edge_first;
  logic edge_first_inv;
  logic edge_second;
  logic cnt_tick;
  logic match;
  logic step_clear;
  logic cap_second;
  logic cap_first;
  logic wr_en;
  logic rd_setup;
  logic status_clr;
  logic ovf_event;

  assign running    = timer_mode_reg != TEC_STOP;
  assign event_mode = prescaler_mode_reg.clk_sel == TEC_CLK_EXT;
  assign wr_en      = psel_in && penable_in && pready_out && pwrite_in;
  assign rd_setup   = psel_in && !penable_in;

  always_comb begin
    case (prescaler_mode_reg.clk_sel)
      TEC_CLK_DIV2:  div_tick = (presc & DIV_MASK_2) == DIV_MASK_2;
      TEC_CLK_DIV4:  div_tick = (presc & DIV_MASK_4) == DIV_MASK_4;
      TEC_CLK_DIV16: div_tick = (presc & DIV_MASK_16) == DIV_MASK_16;
      default:       div_tick = (presc & DIV_MASK_8) == DIV_MASK_8;
    endcase
  end

  // In event mode the first pin is filtered at fx/8; otherwise at the count clock.
  assign filt_tick_a = div_tick;

  // An edge is taken only when two samples in a row agree on the new level.
  assign edge_first     = running && filt_tick_a && samp_a == sync_a[1] && sync_a[1] != acc_a
                          && edge_hit(acc_a, sync_a[1],
                                      prescaler_mode_reg.edge_sel_first);
  assign edge_first_inv = running && filt_tick_a && samp_a == sync_a[1] && sync_a[1] != acc_a
                          && !edge_hit(acc_a, sync_a[1],
                                       prescaler_mode_reg.edge_sel_first);
  assign edge_second    = running && div_tick && samp_b == sync_b[1] && sync_b[1] != acc_b
                          && edge_hit(acc_b, sync_b[1],
                                      prescaler_mode_reg.edge_sel_second);

  assign cnt_tick   = running && (event_mode ? edge_first : div_tick);
  assign match      = main_counter == capcmp_reg_first;
  assign step_clear = cnt_tick && ((timer_mode_reg == TEC_CLR_MATCH && match)
                      || (timer_mode_reg == TEC_CLR_EDGE && edge_first && !event_mode));
  assign ovf_event  = cnt_tick && main_counter == CNT_MAX;

  // A pin that clocks the counter cannot also trigger a capture.
  assign cap_second = edge_first && !event_mode && capture_control_reg.capture_ctrl_bit2;
  assign cap_first  = capture_control_reg.capture_ctrl_bit0
                      && (capture_control_reg.capture_ctrl_bit1
                          ? (edge_first_inv && !event_mode
                             && prescaler_mode_reg.edge_sel_first != EDGE_BOTH)
                          : edge_second);

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      presc <= 4'h0;
    end else begin
      presc <= presc + 4'h1;
    end
  end

  // Two flip-flops before the filter sees either pin.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      sync_a <= 2'b00;
      sync_b <= 2'b00;
    end else begin
      sync_a <= {sync_a[0], ext_input_first_in};
      sync_b <= {sync_b[0], ext_input_second_in};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      samp_a <= 1'b0;
      samp_b <= 1'b0;
    end else begin
      if (filt_tick_a) begin
        samp_a <= sync_a[1];
      end
      if (div_tick) begin
        samp_b <= sync_b[1];
      end
    end
  end

  // Accepted levels start low, so a pin held high out of reset shows a rising
  // edge at first start; once the timer has run, a stopped timer tracks the
  // pins silently and restart sees no stale edge.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      acc_a    <= 1'b0;
      acc_b    <= 1'b0;
      ran_once <= 1'b0;
    end else begin
      if (running) begin
        ran_once <= 1'b1;
      end
      if (!running && ran_once) begin
        acc_a <= sync_a[1];
        acc_b <= sync_b[1];
      end else if (running) begin
        if (filt_tick_a && samp_a == sync_a[1]) begin
          acc_a <= sync_a[1];
        end
        if (div_tick && samp_b == sync_b[1]) begin
          acc_b <= sync_b[1];
        end
      end
    end
  end

  // Counting begins at whatever phase the prescaler holds, so the first
  // period may be short by up to one count clock.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      main_counter <= CNT_ZERO;
    end else if (!running) begin
      main_counter <= CNT_ZERO;
    end else if (step_clear) begin
      main_counter <= CNT_ZERO;
    end else if (cnt_tick) begin
      main_counter <= main_counter + CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      overflow_flag <= 1'b0;
      ovf_hold      <= 1'b0;
    end else begin
      if (ovf_event) begin
        ovf_hold <= 1'b1;
      end else if (cnt_tick || !running) begin
        ovf_hold <= 1'b0;
      end
      if (ovf_event || ovf_hold) begin
        overflow_flag <= 1'b1;
      end else if (status_clr) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Captures fire on the count tick, or on the fx/8 tick in event mode; the pulse follows two cycles later.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      capcmp_reg_first  <= CNT_ZERO;
      capcmp_reg_second <= CNT_ZERO;
    end else begin
      if (cap_first) begin
        capcmp_reg_first <= main_counter;
      end else if (wr_en && paddr_in == OFS_CC_FIRST) begin
        capcmp_reg_first <= pwdata_in[15:0];
      end
      if (cap_second) begin
        capcmp_reg_second <= main_counter;
      end else if (wr_en && paddr_in == OFS_CC_SECND) begin
        capcmp_reg_second <= pwdata_in[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pend_first             <= 1'b0;
      pend_second            <= 1'b0;
      first_match_irq_out    <= 1'b0;
      second_capture_irq_out <= 1'b0;
    end else begin
      pend_first             <= cap_first;
      pend_second            <= cap_second;
      first_match_irq_out    <= pend_first
                                || (step_clear && timer_mode_reg == TEC_CLR_MATCH);
      second_capture_irq_out <= pend_second;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      timer_output_pin_out <= 1'b0;
      timer_output_oe_out  <= 1'b0;
    end else begin
      timer_output_oe_out <= output_control_reg[0] && !event_mode;
      if (!output_control_reg[0] || event_mode) begin
        timer_output_pin_out <= 1'b0;
      end else if (output_control_reg[1] && cnt_tick && match) begin
        timer_output_pin_out <= !timer_output_pin_out;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      timer_mode_reg      <= TEC_STOP;
      prescaler_mode_reg  <= tec_presc_t'(REG8_RST);
      capture_control_reg <= tec_capctrl_t'(REG8_RST);
      output_control_reg  <= REG8_RST;
    end else if (wr_en) begin
      case (paddr_in)
        OFS_MODE:    timer_mode_reg      <= tec_mode_t'(pwdata_in[3:2]);
        OFS_PRESC:   prescaler_mode_reg  <= tec_presc_t'(pwdata_in[7:0]);
        OFS_CAPCTRL: capture_control_reg <= tec_capctrl_t'(pwdata_in[7:0]);
        OFS_OUTCTRL: output_control_reg  <= pwdata_in[7:0];
        default:     output_control_reg  <= output_control_reg;
      endcase
    end
  end

  assign status_clr = wr_en && paddr_in == OFS_STATUS && !pwdata_in[0];

  // One wait state: pready is high in the second access cycle.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      if (rd_setup) begin
        pslverr_out <= 1'b0;
        prdata_out  <= 32'h0000_0000;
        case (paddr_in)
          OFS_MODE:     prdata_out[3:2]  <= timer_mode_reg;
          OFS_PRESC:    prdata_out[7:0]  <= prescaler_mode_reg;
          OFS_CAPCTRL:  prdata_out[7:0]  <= capture_control_reg;
          OFS_OUTCTRL:  prdata_out[7:0]  <= output_control_reg;
          OFS_COUNTER:  prdata_out[15:0] <= main_counter;
          OFS_CC_FIRST: prdata_out[15:0] <= capcmp_reg_first;
          OFS_CC_SECND: prdata_out[15:0] <= capcmp_reg_second;
          OFS_STATUS:   prdata_out[0]    <= overflow_flag;
          default:      pslverr_out      <= 1'b1;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_match_tick;
    cnt_tick && match && timer_mode_reg == TEC_CLR_MATCH;
  endsequence
  sequence s_cap_pulse;
    ##1 pend_second ##1 second_capture_irq_out;
  endsequence

  evt_no_drive_a: assert property (event_mode |=> !timer_output_oe_out)
    else $error("output driven in event mode");
  ovf_wrap_a: assert property (ovf_event |=> overflow_flag)
    else $error("overflow flag not set on wrap");
  ovf_hold_a: assert property (ovf_hold && status_clr |=> overflow_flag)
    else $error("overflow clear took effect too early");
  toggle_match_a: assert property (output_control_reg[1:0] == 2'b11 && !event_mode
                                   && cnt_tick && match
                                   |=> timer_output_pin_out != $past(timer_output_pin_out))
    else $error("output did not toggle on match");
  stop_ignore_a: assert property (!running |-> !edge_first && !edge_second)
    else $error("edge accepted while stopped");
  cap_irq_delay_a: assert property (cap_second |-> s_cap_pulse)
    else $error("capture pulse not two cycles after edge");
  no_cap_evt_a: assert property (event_mode |-> !cap_second)
    else $error("capture from count pin");
  no_cap_both_a: assert property (prescaler_mode_reg.edge_sel_first == EDGE_BOTH
                                  && capture_control_reg.capture_ctrl_bit1 |-> !cap_first)
    else $error("first register captured on both edges");
  match_clear_a: assert property (s_match_tick |=> main_counter == CNT_ZERO
                                  && first_match_irq_out)
    else $error("match did not clear counter");
  read_no_latch_a: assert property (rd_setup && paddr_in == OFS_COUNTER && !cap_second
                                    |=> $stable(capcmp_reg_second))
    else $error("counter read changed capture register");
  compare_mode_a: assert property (!capture_control_reg.capture_ctrl_bit2 |-> !cap_second)
    else $error("compare register captured");
endmodule // tec_timer
`default_nettype wire

// file: test/tec_pulse_src.sv
// Partner model: drives the two external input pins of the timer.
// Assumes the bench calls pulse() from one thread, one pulse at a time.
`timescale 1ns/1ps
`default_nettype none
module tec_pulse_src (
  input  wire logic sys_clk_in,
  output logic      ext_input_first_out,
  output logic      ext_input_second_out
);
  // Pins rest low, so no rising edge is seen straight after reset.
  initial begin
    ext_input_first_out = 1'b0;
    ext_input_second_out = 1'b0;
  end

  // Widths above two count clocks, or the filter would drop the pulse.
  task automatic pulse(input logic sel, input int hi, input int lo);
    @(posedge sys_clk_in);
    if (sel) ext_input_second_out <= 1'b1;
    else ext_input_first_out <= 1'b1;
    repeat (hi) @(posedge sys_clk_in);
    if (sel) ext_input_second_out <= 1'b0;
    else ext_input_first_out <= 1'b0;
    repeat (lo) @(posedge sys_clk_in);
  endtask
endmodule // tec_pulse_src
`default_nettype wire

// file: test/tec_timer_tb.sv
// Self-checking bench for the timer/event counter.
// Assumes pins idle low; an APB wait ends only when pready comes or the watchdog fires.
`timescale 1ns/1ps
`default_nettype none
module tec_timer_tb;
  import tec_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic        err;
  } tec_row_t;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire logic   in_first;
  wire logic   in_second;
  logic        pin;
  logic        oe;
  logic        irq_first;
  logic        irq_second;
  logic [31:0] rd;
  logic [31:0] keep;
  logic        er;
  int          num_errors = 0;
  int          checked = 0;
  int          n_first = 0;
  int          n_second = 0;
  int          base;
  int          n;

  // Reset values first, then a hole, read-back and a read-only write.
  tec_row_t rows [0:16] = '{
    '{1'b0, OFS_MODE, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_PRESC, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_CAPCTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_OUTCTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_COUNTER, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_CC_FIRST, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_CC_SECND, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}, '{1'b1, OFS_PRESC, 32'hf3, 32'h0, 1'b0},
    '{1'b0, OFS_PRESC, 32'h0, 32'hf3, 1'b0}, '{1'b1, OFS_CAPCTRL, 32'h7, 32'h0, 1'b0},
    '{1'b0, OFS_CAPCTRL, 32'h0, 32'h7, 1'b0}, '{1'b1, OFS_CC_FIRST, 32'h1234, 32'h0, 1'b0},
    '{1'b0, OFS_CC_FIRST, 32'h0, 32'h1234, 1'b0}, '{1'b1, OFS_COUNTER, 32'h5555, 32'h0, 1'b0},
    '{1'b0, OFS_COUNTER, 32'h0, 32'h0, 1'b0}};

  always #20 sys_clk = ~sys_clk;

  tec_timer tec_timer_i (
    .sys_clk_in             (sys_clk),
    .rstn_in                (rstn),
    .psel_in                (psel),
    .penable_in             (penable),
    .pwrite_in              (pwrite),
    .paddr_in               (paddr),
    .pwdata_in              (pwdata),
    .prdata_out             (prdata),
    .pready_out             (pready),
    .pslverr_out            (pslverr),
    .ext_input_first_in     (in_first),
    .ext_input_second_in    (in_second),
    .timer_output_pin_out   (pin),
    .timer_output_oe_out    (oe),
    .first_match_irq_out    (irq_first),
    .second_capture_irq_out (irq_second)
  );

  tec_pulse_src tec_pulse_src_i (
    .sys_clk_in           (sys_clk),
    .ext_input_first_out  (in_first),
    .ext_input_second_out (in_second)
  );

  always @(posedge sys_clk) begin
    if (irq_first === 1'b1) n_first++;
    if (irq_second === 1'b1) n_second++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high; read data taken at that edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Counts cycles until the output pin changes level, bounded.
  task automatic gap(output int cnt);
    logic p;
    p = pin;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (pin === p && cnt < 300);
    if (cnt >= 300) num_errors++;
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) chk(rd, rows[i].exp);
      chk({31'h0, er}, {31'h0, rows[i].err});
    end
    // Event counting: edge chosen while stopped, nonzero compare value.
    wr(OFS_CAPCTRL, 32'h0);
    wr(OFS_PRESC, 32'h13);
    wr(OFS_CC_FIRST, 32'h3);
    wr(OFS_OUTCTRL, 32'h3);
    wr(OFS_MODE, 32'hc);
    base = n_first;
    repeat (2) tec_pulse_src_i.pulse(1'b0, 48, 48);
    rdc(OFS_COUNTER, 32'h2);
    chk({31'h0, oe}, 32'h0);
    repeat (2) tec_pulse_src_i.pulse(1'b0, 48, 48);
    chk(32'(n_first - base), 32'h1);
    rdc(OFS_STATUS, 32'h0);
    wr(OFS_MODE, 32'h0);
    // Square wave: match at 4 on a divide-by-2 clock gives 10 cycles a level.
    wr(OFS_PRESC, 32'h0);
    wr(OFS_CC_FIRST, 32'h4);
    wr(OFS_MODE, 32'hc);
    gap(n);
    gap(n);
    chk(32'(n), 32'd10);
    gap(n);
    chk(32'(n), 32'd10);
    chk({31'h0, oe}, 32'h1);
    wr(OFS_MODE, 32'h0);
    // Second register captures on a rising first pin, free-running.
    wr(OFS_PRESC, 32'h10);
    wr(OFS_CAPCTRL, 32'h4);
    wr(OFS_MODE, 32'h8);
    base = n_second;
    tec_pulse_src_i.pulse(1'b0, 16, 16);
    chk(32'(n_second - base), 32'h1);
    apb(1'b0, OFS_CC_SECND, 32'h0);
    keep = rd;
    apb(1'b0, OFS_COUNTER, 32'h0);
    apb(1'b0, OFS_COUNTER, 32'h0);
    rdc(OFS_CC_SECND, keep);
    chk(32'(n_second - base), 32'h1);
    wr(OFS_MODE, 32'h0);
    tec_pulse_src_i.pulse(1'b0, 16, 16);
    chk(32'(n_second - base), 32'h1);
    // Both first-pin edges selected: first register must not capture.
    wr(OFS_PRESC, 32'h30);
    wr(OFS_CAPCTRL, 32'h3);
    wr(OFS_MODE, 32'h8);
    base = n_first;
    repeat (2) tec_pulse_src_i.pulse(1'b0, 16, 16);
    chk(32'(n_first - base), 32'h0);
    wr(OFS_MODE, 32'h0);
    // Rising edge selected: the falling inverse edge does capture into the first register.
    wr(OFS_PRESC, 32'h10);
    wr(OFS_MODE, 32'h8);
    base = n_first;
    tec_pulse_src_i.pulse(1'b0, 16, 16);
    chk(32'(n_first - base), 32'h1);
    // Reset in mid-run: registers and the output enable return to zero.
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rdc(OFS_MODE, 32'h0);
    rdc(OFS_CC_FIRST, 32'h0);
    chk({31'h0, oe}, 32'h0);
    wrap_up();
  end
endmodule // tec_timer_tb
`default_nettype wire
